/* File: src/imu_spi_slave_port.sv */
// serial peripheral slave port giving a host access to the sensor registers
//
// Overview of operation
// (R1) four-wire: select, clock, data in, data out
// (R2) three-wire: one shared bidirectional data line
// (R3) data-in pin becomes bidirectional in three-wire
// (R4) accept mode 0 or 3, detected automatically
// (R5) control register bit 7 selects three-wire
// (R6) sample incoming data on rising clock edge
// (R7) change outgoing data on falling clock edge
// (R8) host keeps serial clock at most 15 MHz
// (R9) every byte shifts most significant bit first
// (R10) single and burst reads and writes supported
// (R11) host writes configuration registers singly only
// (R12) first byte: read flag then seven address bits
// (R13) data bytes are eight bits, D7 first
// (R14) host drives shared line during three-wire writes
// (R15) three-wire read: device drives after address byte
// (R16) host holds select low whole transfer
// (R17) host reads and writes configuration registers here
// (R18) select active low; output floats when idle
// (R19) burst read advances address after each byte
`timescale 1ns/10ps
`include "imu_spi_defines.svh"

module imu_spi_slave_port (
    input wire logic mclk, // system clock, 100 MHz
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic chip_select_n, // chip select pin, active low
    input wire logic serial_clock_pin, // serial clock from host
    input wire logic host_to_device_line_in, // data-in pin level
    output logic host_to_device_line_out, // data-in pin drive value (three-wire)
    output logic host_to_device_line_oe, // data-in pin drive enable
    output logic device_to_host_line_out, // data-out pin drive value (four-wire)
    output logic device_to_host_line_oe, // data-out pin drive enable
    output imu_spi_pkg::reg_req_t reg_req, // register access strobes
    input wire logic [7:0] reg_rdata, // read data, valid while reg_req.rd is high
    output logic three_wire_mode, // copy of control register bit 7
    output logic mode3_seen // clock idled high at last select
);
    import imu_spi_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic cs_sync1, cs_sync2, cs_prev; // select chain
    logic clk_sync1, clk_sync2, clk_prev; // serial clock chain
    logic di_sync1, di_sync2; // data-in chain

    // two flops per pin, plus a third on select and clock for edge detection; first stage feeds only the second
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync1 <= 1'b1;
            cs_sync2 <= 1'b1;
            cs_prev <= 1'b1;
            clk_sync1 <= 1'b0;
            clk_sync2 <= 1'b0;
            clk_prev <= 1'b0;
            di_sync1 <= 1'b0;
            di_sync2 <= 1'b0;
        end else begin
            cs_sync1 <= chip_select_n;
            cs_sync2 <= cs_sync1;
            cs_prev <= cs_sync2;
            clk_sync1 <= serial_clock_pin;
            clk_sync2 <= clk_sync1;
            clk_prev <= clk_sync2;
            di_sync1 <= host_to_device_line_in;
            di_sync2 <= di_sync1;
        end
    end

    logic rise, fall, cs_fall; // edge events, valid only while selected
    assign rise = clk_sync2 & ~clk_prev & ~cs_sync2;
    assign fall = ~clk_sync2 & clk_prev & ~cs_sync2;
    assign cs_fall = cs_prev & ~cs_sync2;

    // ------------------------------------------------------------
    // transfer engine
    // ------------------------------------------------------------
    spi_state_t state, next_state; // transfer phase
    logic [2:0] bit_cnt, next_bit_cnt; // bits taken in current byte
    logic [7:0] shift_in, next_shift_in; // incoming byte
    logic [7:0] shift_out, next_shift_out; // outgoing byte
    logic [6:0] addr, next_addr; // current register address
    logic load_pend, next_load_pend; // read data arrives this cycle
    logic out_bit, next_out_bit; // bit being driven
    logic out_en, next_out_en; // device owns the data line
    logic three_wire, next_three_wire; // wire mode select
    logic idle_high, next_idle_high; // detected clock polarity
    reg_req_t req, next_req; // register strobes
    pins_t pins, next_pins; // registered pin drivers
    logic [7:0] byte_in; // byte including the bit sampled now

    // next-state logic for the whole port
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift_in = shift_in;
        next_shift_out = shift_out;
        next_addr = addr;
        next_load_pend = 1'b0;
        next_out_bit = out_bit;
        next_out_en = out_en;
        next_three_wire = three_wire;
        next_idle_high = idle_high;
        next_req = req;
        next_req.wr = 1'b0;
        next_req.rd = 1'b0;
        byte_in = {shift_in[6:0], di_sync2}; // msb arrives first (R9) (R6)
        if (cs_fall) begin
            // clock level at select tells mode 0 from mode 3 (R4)
            next_idle_high = clk_sync2;
        end
        if (cs_sync2) begin
            // deselected: release the line and forget the transfer (R18)
            next_state = ST_IDLE;
            next_bit_cnt = 3'h0;
            next_out_en = 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    next_state = ST_ADDR;
                    next_bit_cnt = 3'h0;
                end
                ST_ADDR: begin
                    // a mode 3 leading fall is simply ignored here (R4)
                    if (rise) begin
                        next_shift_in = byte_in;
                        next_bit_cnt = bit_cnt + 3'h1;
                        if (bit_cnt == `SPI_LAST_BIT) begin
                            next_addr = byte_in[6:0]; // (R12)
                            if (byte_in[`SPI_DIR_BIT]) begin
                                next_state = ST_READ;
                                next_req.rd = 1'b1; // (R17)
                                next_req.addr = byte_in[6:0];
                                next_load_pend = 1'b1;
                            end else begin
                                next_state = ST_WRITE;
                            end
                        end
                    end
                end
                ST_WRITE: begin
                    if (rise) begin
                        next_shift_in = byte_in;
                        next_bit_cnt = bit_cnt + 3'h1;
                        if (bit_cnt == `SPI_LAST_BIT) begin
                            // whole data byte in: strobe and step for burst (R13) (R10)
                            next_req.wr = 1'b1; // (R17)
                            next_req.addr = addr;
                            next_req.wdata = byte_in;
                            next_addr = addr + `SPI_ADDR_STEP;
                            if (addr == `SPI_FIRST_CONTROL_ADDR) begin
                                next_three_wire = byte_in[`SPI_WIRE_MODE_BIT]; // (R5)
                            end
                        end
                    end
                end
                ST_READ: begin
                    if (load_pend) begin
                        next_shift_out = reg_rdata;
                    end
                    if (fall) begin
                        // new bit only on falling edge, msb first (R7) (R9) (R15)
                        next_out_bit = shift_out[7];
                        next_shift_out = {shift_out[6:0], 1'b0};
                        next_out_en = 1'b1;
                    end
                    if (rise) begin
                        next_bit_cnt = bit_cnt + 3'h1;
                        if (bit_cnt == `SPI_LAST_BIT) begin
                            // prefetch the following register for a burst (R19) (R10)
                            next_addr = addr + `SPI_ADDR_STEP;
                            next_req.rd = 1'b1;
                            next_req.addr = addr + `SPI_ADDR_STEP;
                            next_load_pend = 1'b1;
                        end
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
        // four-wire drives the data-out pin, three-wire the shared pin (R1) (R2) (R3)
        next_pins.d2h = next_out_bit;
        next_pins.h2d = next_out_bit;
        next_pins.d2h_oe = next_out_en & ~next_three_wire;
        next_pins.h2d_oe = next_out_en & next_three_wire;
    end

    // state registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            bit_cnt <= 3'h0;
            shift_in <= 8'h00;
            shift_out <= 8'h00;
            addr <= 7'h00;
            load_pend <= 1'b0;
            out_bit <= 1'b0;
            out_en <= 1'b0;
            three_wire <= `SPI_WIRE_MODE_RST; // four-wire after reset (R5)
            idle_high <= 1'b0;
            req <= '0;
            pins <= '0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift_in <= next_shift_in;
            shift_out <= next_shift_out;
            addr <= next_addr;
            load_pend <= next_load_pend;
            out_bit <= next_out_bit;
            out_en <= next_out_en;
            three_wire <= next_three_wire;
            idle_high <= next_idle_high;
            req <= next_req;
            pins <= next_pins;
        end
    end

    assign host_to_device_line_out = pins.h2d;
    assign host_to_device_line_oe = pins.h2d_oe;
    assign device_to_host_line_out = pins.d2h;
    assign device_to_host_line_oe = pins.d2h_oe;
    assign reg_req = req;
    assign three_wire_mode = three_wire;
    assign mode3_seen = idle_high;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence addr_read_done;
        state == ST_ADDR && rise && bit_cnt == 3'h7 && shift_in[6];
    endsequence

    sequence read_byte_done;
        state == ST_READ && rise && bit_cnt == 3'h7;
    endsequence

    idle_release_a: assert property (@(posedge mclk) disable iff (!rst_n) // (R18)
        cs_sync2 |=> !pins.d2h_oe && !pins.h2d_oe)
        else $error("data line driven while deselected");

    addr_hiz_a: assert property (@(posedge mclk) disable iff (!rst_n) // (R18)
        state == ST_ADDR |-> !pins.d2h_oe && !pins.h2d_oe)
        else $error("data line driven during address byte");

    wire_select_a: assert property (@(posedge mclk) disable iff (!rst_n) // (R3)
        (pins.h2d_oe |-> three_wire) and (pins.d2h_oe |-> !three_wire))
        else $error("wrong pin driven for wire mode");

    fall_change_a: assert property (@(posedge mclk) disable iff (!rst_n) // (R7)
        $changed(pins.d2h) |-> $past(fall))
        else $error("output bit changed away from falling edge");

    write_strobe_a: assert property (@(posedge mclk) disable iff (!rst_n) // (R13)
        req.wr |-> $past(rise) && $past(bit_cnt) == 3'h7 && $past(state) == ST_WRITE)
        else $error("write strobe not after eighth data bit");

    read_start_a: assert property (@(posedge mclk) disable iff (!rst_n) // (R12)
        addr_read_done |=> req.rd && load_pend && state == ST_READ)
        else $error("read flag did not start a read");

    burst_step_a: assert property (@(posedge mclk) disable iff (!rst_n) // (R19)
        read_byte_done |=> req.rd && req.addr == 7'($past(addr) + 7'h01))
        else $error("burst read address did not advance");

    mode_detect_a: assert property (@(posedge mclk) disable iff (!rst_n) // (R4)
        cs_fall |=> idle_high == $past(clk_sync2))
        else $error("clock polarity not captured at select");

    rdata_load_a: assert property (@(posedge mclk) disable iff (!rst_n) // (R15)
        (load_pend && !cs_sync2 && !fall && state == ST_READ) |=> shift_out == $past(reg_rdata))
        else $error("read data not loaded");
endmodule

/* File: shared/imu_spi_defines.svh */
// constants for the serial register port: field positions, reset values, addresses
`ifndef IMU_SPI_DEFINES_SVH
`define IMU_SPI_DEFINES_SVH
`define SPI_ADDR_W 7
`define SPI_DATA_W 8
`define SPI_DIR_BIT 7
`define SPI_LAST_BIT 3'h7
`define SPI_FIRST_CONTROL_ADDR 7'h02
`define SPI_WIRE_MODE_BIT 7
`define SPI_WIRE_MODE_RST 1'h0
`define SPI_ADDR_STEP 7'h01
`endif

/* File: shared/imu_spi_pkg.sv */
// types shared by the serial register port and its bench
package imu_spi_pkg;
    // one-hot transfer phases
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_ADDR  = 4'h2,
        ST_WRITE = 4'h4,
        ST_READ  = 4'h8
    } spi_state_t;

    // request toward the register file
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // serial pin drivers
    typedef struct packed {
        logic d2h;
        logic d2h_oe;
        logic h2d;
        logic h2d_oe;
    } pins_t;
endpackage

/* File: dv/spi_host_model.sv */
// host master model that drives the serial register port from the far side
`timescale 1ns/10ps

module spi_host_model (
    output logic chip_select_n, // select toward device, active low
    output logic serial_clock_pin, // serial clock toward device
    output logic host_to_device_line, // resolved level of the data-in pin
    input wire logic h2d_out, // device drive value on the data-in pin
    input wire logic h2d_oe, // device drives the data-in pin
    input wire logic d2h_out, // device value on the data-out pin
    input wire logic d2h_oe, // device drives the data-out pin
    output logic addr_phase // high while the command byte is shifted
);
    // ------------------------------------------------------------
    // link timing and line resolution
    // ------------------------------------------------------------
    localparam realtime HALF = 62.5; // 8 MHz link, well under the ceiling
    logic hbit; // host drive value; toggles once released so stale levels never pass
    logic [7:0] rx_q[$]; // bytes gathered by reads
    // the shared line shows the device only while it drives
    assign host_to_device_line = h2d_oe ? h2d_out : hbit;
    initial begin
        chip_select_n = 1'b1;
        serial_clock_pin = 1'b0;
        hbit = 1'b0;
        addr_phase = 1'b0;
    end
    // one byte, msb first; data moves only just after the falling edge
    task automatic shift_byte(input logic [7:0] tx, input logic drv, input logic tw, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            serial_clock_pin = 1'b0;
            hbit = drv ? tx[i] : ~hbit;
            #(HALF);
            serial_clock_pin = 1'b1;
            rx[i] = tw ? host_to_device_line : (d2h_oe ? d2h_out : ~hbit);
            #(HALF);
        end
    endtask
    // whole transfer; burst data counts up from wd, n data bytes are sent whatever the address, configuration registers included
    task automatic xfer(input logic rd, input logic [6:0] addr, input int n, input logic [7:0] wd,
                        input logic m3, input logic tw);
        logic [7:0] b;
        serial_clock_pin = m3; // idle level selects the clock mode
        #(HALF);
        chip_select_n = 1'b0;
        addr_phase = 1'b1;
        #(HALF);
        shift_byte({rd, addr}, 1'b1, tw, b);
        addr_phase = 1'b0;
        for (int k = 0; k < n; k++) begin
            shift_byte(wd + 8'(k), !rd, tw, b);
            if (rd) rx_q.push_back(b);
        end
        serial_clock_pin = m3;
        #(HALF);
        chip_select_n = 1'b1;
        #(4 * HALF);
    endtask
endmodule

/* File: dv/test_imu_spi_slave_port.sv */
// self-checking bench for the serial register port
`timescale 1ns/10ps

module test_imu_spi_slave_port;
    import imu_spi_pkg::*;
    logic mclk, rst_n, cs_n, sclk, h2d_line, h2d_out, h2d_oe, d2h_out, d2h_oe;
    logic three_wire_mode, mode3_seen, addr_phase;
    reg_req_t reg_req;
    logic [7:0] reg_rdata;
    int num_errors = 0;
    int comparisons = 0;
    int bad_oe = 0; // device drive seen where the pin must float
    int cs_idle = 0; // cycles since select went high
    logic [14:0] wr_q[$]; // address and data of each write strobe
    logic [6:0] rd_q[$]; // address of each read strobe
    // ------------------------------------------------------------
    // register file stand-in: data depends only on the address
    // ------------------------------------------------------------
    function automatic logic [7:0] reg_val(input logic [6:0] a);
        return {a[0], a ^ 7'h55};
    endfunction
    assign reg_rdata = reg_val(reg_req.addr);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    imu_spi_slave_port u_imu_spi_slave_port (.mclk(mclk), .rst_n(rst_n), .chip_select_n(cs_n),
        .serial_clock_pin(sclk), .host_to_device_line_in(h2d_line), .host_to_device_line_out(h2d_out),
        .host_to_device_line_oe(h2d_oe), .device_to_host_line_out(d2h_out), .device_to_host_line_oe(d2h_oe),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .three_wire_mode(three_wire_mode), .mode3_seen(mode3_seen));
    spi_host_model u_spi_host_model (.chip_select_n(cs_n), .serial_clock_pin(sclk),
        .host_to_device_line(h2d_line), .h2d_out(h2d_out), .h2d_oe(h2d_oe), .d2h_out(d2h_out),
        .d2h_oe(d2h_oe), .addr_phase(addr_phase));
    // strobe log and float watch; oe may linger a few cycles after select rises
    always @(posedge mclk) begin
        cs_idle <= cs_n ? cs_idle + 1 : 0;
        if (reg_req.wr === 1'b1) wr_q.push_back({reg_req.addr, reg_req.wdata});
        if (reg_req.rd === 1'b1) rd_q.push_back(reg_req.addr);
        if ((addr_phase || cs_idle > 6) && (d2h_oe !== 1'b0 || h2d_oe !== 1'b0)) bad_oe++;
        if (three_wire_mode === 1'b0 && h2d_oe !== 1'b0) bad_oe++;
        if (three_wire_mode === 1'b1 && d2h_oe !== 1'b0) bad_oe++;
    end
    // ------------------------------------------------------------
    // comparison and verdict
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic reset_values();
        check("reset outputs", {10'h0, h2d_oe, d2h_oe, three_wire_mode, mode3_seen, reg_req.wr, reg_req.rd},
              16'h0000);
    endtask
    task automatic single_write_mode0();
        wr_q.delete();
        u_spi_host_model.xfer(1'b0, 7'h15, 1, 8'ha5, 1'b0, 1'b0);
        check("write count", 16'(wr_q.size()), 16'h0001);
        check("write strobe", {1'b0, wr_q[0]}, {1'b0, 7'h15, 8'ha5});
        check("mode 0 seen", {15'h0, mode3_seen}, 16'h0000);
    endtask
    task automatic burst_read_mode3();
        rd_q.delete();
        u_spi_host_model.rx_q.delete();
        u_spi_host_model.xfer(1'b1, 7'h7e, 3, 8'h00, 1'b1, 1'b0);
        check("read count", 16'(u_spi_host_model.rx_q.size()), 16'h0003);
        for (int k = 0; k < 3; k++) begin
            check("burst data", {8'h0, u_spi_host_model.rx_q[k]}, {8'h0, reg_val(7'h7e + 7'(k))});
            check("burst addr", {9'h0, rd_q[k]}, {9'h0, 7'h7e + 7'(k)});
        end
        check("mode 3 seen", {15'h0, mode3_seen}, 16'h0001);
    endtask
    task automatic three_wire_round();
        u_spi_host_model.rx_q.delete();
        u_spi_host_model.xfer(1'b0, 7'h02, 1, 8'h80, 1'b0, 1'b0);
        check("three-wire on", {15'h0, three_wire_mode}, 16'h0001);
        u_spi_host_model.xfer(1'b1, 7'h33, 1, 8'h00, 1'b0, 1'b1);
        check("shared line read", {8'h0, u_spi_host_model.rx_q[0]}, {8'h0, reg_val(7'h33)});
        u_spi_host_model.xfer(1'b0, 7'h02, 1, 8'h00, 1'b1, 1'b1);
        check("three-wire off", {15'h0, three_wire_mode}, 16'h0000);
    endtask
    task automatic burst_write_mode3();
        wr_q.delete();
        u_spi_host_model.xfer(1'b0, 7'h10, 2, 8'h3c, 1'b1, 1'b0);
        check("burst write count", 16'(wr_q.size()), 16'h0002);
        check("burst write 0", {1'b0, wr_q[0]}, {1'b0, 7'h10, 8'h3c});
        check("burst write 1", {1'b0, wr_q[1]}, {1'b0, 7'h11, 8'h3d});
    endtask
    initial begin
        rst_n = 1'b0;
        repeat (20) @(posedge mclk);
        reset_values();
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        single_write_mode0();
        burst_read_mode3();
        three_wire_round();
        burst_write_mode3();
        check("float violations", 16'(bad_oe), 16'h0000);
        close_out();
    end
    // hang guard
    initial begin
        repeat (100000) @(posedge mclk);
        num_errors++;
        close_out();
    end
endmodule
